// ---- core/cpw_timer.sv ----
// Purpose: 16-bit cascaded timer, programmable pulse and warm-up counter modes
// Assumes: classic wishbone slave, 8-bit registers in byte lane 0 of each word
// Notes: registers apply at once; no shadow copies of the compare values
// Operation
// - two 8-bit counters form one 16-bit counter
// - width match inverts output, counting continues
// - period match inverts output, clears, requests interrupt
// - preset bit loads output flip-flop; reset clears
// - output pin is inverse of flip-flop
// - compare writes act immediately; avoid while running
// - stop holds pin; preset only after stop
// - stopped, clearing bit 7 drives pin high
// - 057H selects pulse mode, 05FH starts
// - warm-up counter mode, both switch directions
// - warm-up compares only upper period byte
// - warm-up match clears counter, requests interrupt
// - 0100H gives 7.81 ms, FF00H 1.99 s
// - 05H selects warm-up mode, preset zero
`timescale 1ns/1ns
`include "cpw_consts.svh"
module cpw_timer #(
  parameter int ADR_W = 8,
  parameter int COUNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin,
  input wire logic low_freq_clk_pin,
  output logic pulse_output_pin,
  output logic period_interrupt
);
  logic [7:0] lower_control_reg;
  logic [7:0] upper_control_reg;
  logic [7:0] period_compare_low_reg, period_compare_high_reg;
  logic [7:0] width_compare_low_reg, width_compare_high_reg;
  logic [COUNT_W-1:0] count_reg;
  logic output_flipflop_reg;
  logic irq_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic count_tick;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] adr_byte;
  logic run_bit;
  cpw_pkg::cpw_mode_e mode;
  cpw_pkg::cpw_count_t period_value, width_value, warm_value;
  logic period_hit, width_hit, warm_hit;
  logic upper_wr;

  // ----------------------------------------
  // count-clock source
  // ----------------------------------------
  cpw_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .source_select(lower_control_reg[`CPW_LC_SRC_MSB:`CPW_LC_SRC_LSB]),
    .external_count_pin(external_count_pin),
    .low_freq_clk_pin(low_freq_clk_pin),
    .count_tick(count_tick)
  );

  // ----------------------------------------
  // wishbone slave: ack one cycle after the request
  // ----------------------------------------
  assign adr_byte = {wb_adr_i[7:2], 2'b00};
  // write lands on the edge at which the master sees ack
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign upper_wr = wr_en && adr_byte == `CPW_OFF_UPPER_CTRL;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdat_reg <= `CPW_WORD_ZERO;
    end else if (wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i) begin
      unique case (adr_byte)
        `CPW_OFF_LOWER_CTRL: rdat_reg <= {24'h00_0000, lower_control_reg};
        `CPW_OFF_UPPER_CTRL: rdat_reg <= {24'h00_0000, upper_control_reg};
        `CPW_OFF_PERIOD_LO: rdat_reg <= {24'h00_0000, period_compare_low_reg};
        `CPW_OFF_PERIOD_HI: rdat_reg <= {24'h00_0000, period_compare_high_reg};
        `CPW_OFF_WIDTH_LO: rdat_reg <= {24'h00_0000, width_compare_low_reg};
        `CPW_OFF_WIDTH_HI: rdat_reg <= {24'h00_0000, width_compare_high_reg};
        `CPW_OFF_COUNT_LO: rdat_reg <= {24'h00_0000, count_reg[7:0]};
        `CPW_OFF_COUNT_HI: rdat_reg <= {24'h00_0000, count_reg[15:8]};
        `CPW_OFF_STATUS: rdat_reg <= {30'h0000_0000, irq_reg, output_flipflop_reg};
        default: rdat_reg <= `CPW_WORD_ZERO;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------
  // control and compare registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lower_control_reg <= `CPW_BYTE_RST;
      upper_control_reg <= `CPW_BYTE_RST;
    end else if (wr_en) begin
      if (adr_byte == `CPW_OFF_LOWER_CTRL) begin
        lower_control_reg <= wr_byte;
      end
      if (adr_byte == `CPW_OFF_UPPER_CTRL) begin
        upper_control_reg <= wr_byte;
      end
    end
  end

  // no shadow copy: a write takes part in the very next compare
  // low then high byte order is on software
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      period_compare_low_reg <= `CPW_BYTE_RST;
      period_compare_high_reg <= `CPW_BYTE_RST;
      width_compare_low_reg <= `CPW_BYTE_RST;
      width_compare_high_reg <= `CPW_BYTE_RST;
    end else if (wr_en) begin
      unique case (adr_byte)
        `CPW_OFF_PERIOD_LO: period_compare_low_reg <= wr_byte;
        `CPW_OFF_PERIOD_HI: period_compare_high_reg <= wr_byte;
        `CPW_OFF_WIDTH_LO: width_compare_low_reg <= wr_byte;
        `CPW_OFF_WIDTH_HI: width_compare_high_reg <= wr_byte;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // mode decode and match detection
  // ----------------------------------------
  assign run_bit = upper_control_reg[`CPW_UC_RUN_BIT];

  always_comb begin
    unique case (upper_control_reg[`CPW_UC_MODE_MSB:`CPW_UC_MODE_LSB])
      `CPW_MODE_PULSE_CODE: mode = cpw_pkg::CPW_MODE_PULSE;
      `CPW_MODE_WARM_CODE: mode = cpw_pkg::CPW_MODE_WARM;
      default: mode = cpw_pkg::CPW_MODE_IDLE;
    endcase
  end

  assign period_value = {period_compare_high_reg, period_compare_low_reg};
  assign width_value = {width_compare_high_reg, width_compare_low_reg};
  // low period byte ignored in warm-up, so count = high * 256 ticks
  assign warm_value = {period_compare_high_reg, `CPW_BYTE_ZERO};
  assign period_hit = mode == cpw_pkg::CPW_MODE_PULSE && count_reg == period_value;
  assign width_hit = mode == cpw_pkg::CPW_MODE_PULSE && count_reg == width_value;
  assign warm_hit = mode == cpw_pkg::CPW_MODE_WARM && count_reg == warm_value;

  // ----------------------------------------
  // 16-bit cascaded up-counter
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= `CPW_COUNT_RST;
    end else if (!run_bit || mode == cpw_pkg::CPW_MODE_IDLE) begin
      count_reg <= `CPW_COUNT_RST;
    end else if (count_tick) begin
      if (period_hit || warm_hit) begin
        count_reg <= `CPW_COUNT_RST;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  // one-cycle request per match, on the tick that clears the counter
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= run_bit & count_tick & (period_hit | warm_hit);
    end
  end

  assign period_interrupt = irq_reg;

  // ----------------------------------------
  // output flip-flop
  // ----------------------------------------
  // preset only loads while already stopped, so a stop write keeps the level
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      output_flipflop_reg <= 1'b0;
    end else if (upper_wr && !run_bit) begin
      output_flipflop_reg <= wr_byte[`CPW_UC_PRESET_BIT];
    end else if (run_bit && count_tick && (period_hit || width_hit)) begin
      output_flipflop_reg <= ~output_flipflop_reg;
    end
  end

  assign pulse_output_pin = ~output_flipflop_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_count_step: assert property (
    run_bit && mode != cpw_pkg::CPW_MODE_IDLE && count_tick && !period_hit && !warm_hit
    && !wr_en |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");

  a_width_toggle: assert property (
    run_bit && count_tick && width_hit && !period_hit && !upper_wr
    |=> output_flipflop_reg != $past(output_flipflop_reg) && count_reg != 16'h0000)
    else $error("width match did not invert output");

  a_period_end: assert property (
    run_bit && count_tick && period_hit && !width_hit && !upper_wr
    |=> period_interrupt && count_reg == 16'h0000
    && output_flipflop_reg != $past(output_flipflop_reg))
    else $error("period match did not clear, invert and interrupt");

  a_warm_match: assert property (
    run_bit && count_tick && warm_hit && !upper_wr
    |=> period_interrupt && count_reg == 16'h0000
    && output_flipflop_reg == $past(output_flipflop_reg))
    else $error("warm-up match wrong");

  a_preset_load: assert property (
    upper_wr && !run_bit |=> output_flipflop_reg == $past(wr_byte[`CPW_UC_PRESET_BIT])
    && pulse_output_pin == !$past(wr_byte[`CPW_UC_PRESET_BIT]))
    else $error("preset did not load output flip-flop");

  a_stop_hold: assert property (
    !run_bit && !upper_wr |=> $stable(output_flipflop_reg))
    else $error("output moved while stopped");

  a_irq_single: assert property (
    period_interrupt && !count_tick |=> !period_interrupt)
    else $error("interrupt longer than one event");

  a_pin_inverse: assert property (
    $rose(output_flipflop_reg) |-> $fell(pulse_output_pin))
    else $error("pin not inverse of flip-flop");

  a_start_mode: assert property (
    upper_wr && wr_byte == 8'h5f |=> run_bit && mode == cpw_pkg::CPW_MODE_PULSE)
    else $error("start write did not run pulse mode");

  a_ack_once: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");

  c_pulse_period: cover property (run_bit && count_tick && period_hit);
  c_pulse_width: cover property (run_bit && count_tick && width_hit && !period_hit);
  c_warm_end: cover property (run_bit && count_tick && warm_hit);
endmodule

// ---- core/cpw_consts.svh ----
// Purpose: named offsets, fields, codes and timing figures of the cascaded timer
// Assumes: included by its bare name from every design file that needs it
// Notes: byte offsets are aligned words on a 32-bit wishbone bus
`ifndef CPW_CONSTS_SVH
`define CPW_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CPW_OFF_LOWER_CTRL 8'h00
`define CPW_OFF_UPPER_CTRL 8'h04
`define CPW_OFF_PERIOD_LO 8'h08
`define CPW_OFF_PERIOD_HI 8'h0c
`define CPW_OFF_WIDTH_LO 8'h10
`define CPW_OFF_WIDTH_HI 8'h14
`define CPW_OFF_COUNT_LO 8'h18
`define CPW_OFF_COUNT_HI 8'h1c
`define CPW_OFF_STATUS 8'h20

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CPW_UC_PRESET_BIT 7
`define CPW_UC_RUN_BIT 3
`define CPW_UC_MODE_MSB 2
`define CPW_UC_MODE_LSB 0
`define CPW_LC_SRC_MSB 6
`define CPW_LC_SRC_LSB 4
`define CPW_BYTE_RST 8'h00
`define CPW_COUNT_RST 16'h0000
`define CPW_BYTE_ZERO 8'h00
`define CPW_WORD_ZERO 32'h0000_0000

// ----------------------------------------
// mode and count source codes
// ----------------------------------------
`define CPW_MODE_PULSE_CODE 3'h7
`define CPW_MODE_WARM_CODE 3'h5
`define CPW_SRC_DIV11 3'h0
`define CPW_SRC_DIV7 3'h1
`define CPW_SRC_DIV5 3'h2
`define CPW_SRC_DIV3 3'h3
`define CPW_SRC_LOWFREQ 3'h4
`define CPW_SRC_DIV1 3'h5
`define CPW_SRC_FULL 3'h6
`define CPW_SRC_EXT_PIN 3'h7
`define CPW_PRESCALE_W 11
`define CPW_MASK_DIV11 11'h7ff
`define CPW_MASK_DIV7 11'h07f
`define CPW_MASK_DIV5 11'h01f
`define CPW_MASK_DIV3 11'h007
`define CPW_MASK_DIV1 11'h001

// ----------------------------------------
// warm-up timing on the low-frequency clock
// ----------------------------------------
`define CPW_LF_CLK_HZ 32768
`define CPW_WARM_MIN_SETTING 16'h0100
`define CPW_WARM_MAX_SETTING 16'hff00
`define CPW_WARM_MIN_US 7810
`define CPW_WARM_MAX_US 1990000
`define CPW_WARM_MIN_TICKS (`CPW_WARM_MIN_US * `CPW_LF_CLK_HZ / 1000000)

`endif

// ---- core/cpw_pkg.sv ----
// Purpose: shared types of the cascaded pulse and warm-up timer
// Assumes: used by scoped name only
// Notes: the mode type lives here, mode decode lives in the timer, codes live in the consts header
package cpw_pkg;
  typedef enum logic [1:0] {
    CPW_MODE_IDLE,
    CPW_MODE_PULSE,
    CPW_MODE_WARM
  } cpw_mode_e;
  typedef logic [15:0] cpw_count_t;
endpackage

// ---- core/cpw_tick_gen.sv ----
// Purpose: count-clock event generator for the cascaded timer
// Assumes: pins are asynchronous to ref_clk and pass two flip-flops first
// Notes: one-cycle tick per count event; external pin counts on falling edges
`timescale 1ns/1ns
`include "cpw_consts.svh"
module cpw_tick_gen #(
  parameter int PRESCALE_W = `CPW_PRESCALE_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [2:0] source_select,
  input wire logic external_count_pin,
  input wire logic low_freq_clk_pin,
  output logic count_tick
);
  logic [PRESCALE_W-1:0] div_reg;
  logic ext_meta_reg, ext_sync_reg, ext_prev_reg;
  logic lf_meta_reg, lf_sync_reg, lf_prev_reg;
  logic ext_fall, lf_rise;

  // ----------------------------------------
  // free-running prescaler
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // pin synchronisers, edge detect after second stage only
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_meta_reg <= 1'b1;
      ext_sync_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
      lf_meta_reg <= 1'b0;
      lf_sync_reg <= 1'b0;
      lf_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= external_count_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
      lf_meta_reg <= low_freq_clk_pin;
      lf_sync_reg <= lf_meta_reg;
      lf_prev_reg <= lf_sync_reg;
    end
  end

  // each level must last two machine cycles or an edge is lost
  assign ext_fall = ext_prev_reg & ~ext_sync_reg;
  assign lf_rise = lf_sync_reg & ~lf_prev_reg;

  always_comb begin
    unique case (source_select)
      `CPW_SRC_DIV11: count_tick = (div_reg & `CPW_MASK_DIV11) == `CPW_MASK_DIV11;
      `CPW_SRC_DIV7: count_tick = (div_reg & `CPW_MASK_DIV7) == `CPW_MASK_DIV7;
      `CPW_SRC_DIV5: count_tick = (div_reg & `CPW_MASK_DIV5) == `CPW_MASK_DIV5;
      `CPW_SRC_DIV3: count_tick = (div_reg & `CPW_MASK_DIV3) == `CPW_MASK_DIV3;
      `CPW_SRC_LOWFREQ: count_tick = lf_rise;
      `CPW_SRC_DIV1: count_tick = (div_reg & `CPW_MASK_DIV1) == `CPW_MASK_DIV1;
      `CPW_SRC_FULL: count_tick = 1'b1;
      `CPW_SRC_EXT_PIN: count_tick = ext_fall;
    endcase
  end
endmodule

// ---- test/cpw_pin_src.sv ----
// Purpose: far-side source of the external count pin and low-frequency clock pin
// Assumes: en is raised only while the timer counts from one of these pins
// Notes: both pins stand still while en is low
`timescale 1ns/1ns
module cpw_pin_src #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  input wire logic en,
  output logic external_count_pin,
  output logic low_freq_clk_pin
);
  int cnt = 0;
  initial begin
    external_count_pin = 1'b1;
    low_freq_clk_pin = 1'b0;
  end
  // each level lasts HALF cycles, well above the two-cycle minimum
  always @(posedge ref_clk) begin
    if (en) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        external_count_pin <= ~external_count_pin;
        low_freq_clk_pin <= ~low_freq_clk_pin;
      end
    end
  end
endmodule

// ---- test/cascaded_pulse_warmup_timer_tb.sv ----
// Purpose: self-checking bench of the cascaded pulse and warm-up timer
// Assumes: one wishbone request at a time, an idle cycle between requests
// Notes: spans are measured from one period interrupt to the next
`timescale 1ns/1ns
`include "cpw_consts.svh"
module cascaded_pulse_warmup_timer_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] v;
  logic ack, ext_pin, lf_pin, pin, irq;
  logic ext_en = 1'b0;
  logic [31:0] seed = 32'hea0e0327;
  logic [2:0] srcs [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  int divs [7] = '{2048, 128, 32, 8, 8, 2, 8};
  int miscompares = 0;
  int n_checks = 0;

  cpw_timer dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_count_pin(ext_pin), .low_freq_clk_pin(lf_pin),
    .pulse_output_pin(pin), .period_interrupt(irq));
  cpw_pin_src src (.ref_clk(ref_clk), .en(ext_en), .external_count_pin(ext_pin),
    .low_freq_clk_pin(lf_pin));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int exp_span(int ticks, int div);
    return ticks * div;
  endfunction
  task automatic summarize();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic fail(string m);
    miscompares++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_bit(logic g, logic e, string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_word(logic [31:0] g, logic [31:0] e, string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_int(int g, int e, string m);
    n_checks++;
    if (g != e) fail(m);
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    sel <= 4'h1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] e, string m);
    wb(1'b0, a, 8'h00);
    chk_word(q, e, m);
  endtask
  task automatic set16(logic [7:0] lo, logic [15:0] d);
    wb(1'b1, lo, d[7:0]);
    wb(1'b1, lo + 8'h04, d[15:8]);
  endtask
  task automatic measure(int lim, output int t_fall, output int t_irq);
    int n;
    n = 0;
    t_fall = -1;
    t_irq = -1;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk_bit(pin, 1'b1, "pin not high at period end");
    n = 0;
    while (t_irq < 0 && n < lim) begin
      @(posedge ref_clk);
      n++;
      if (n == 1) chk_bit(irq, 1'b0, "interrupt longer than one cycle");
      if (t_fall < 0 && pin === 1'b0) t_fall = n;
      if (irq === 1'b1) t_irq = n;
    end
  endtask
  task automatic run_case(logic [2:0] s, int div, logic [15:0] w, logic [15:0] p, logic warm);
    int tf, ti;
    set16(`CPW_OFF_WIDTH_LO, w);
    set16(`CPW_OFF_PERIOD_LO, p);
    wb(1'b1, `CPW_OFF_LOWER_CTRL, {1'b0, s, 4'h0});
    ext_en <= (s == 3'h4 || s == 3'h7);
    wb(1'b1, `CPW_OFF_UPPER_CTRL, warm ? 8'h05 : 8'h57);
    wb(1'b1, `CPW_OFF_UPPER_CTRL, warm ? 8'h0d : 8'h5f);
    measure(4 * (p + 1) * div + 100, tf, ti);
    if (warm) begin
      chk_int(ti, exp_span({p[15:8], 8'h00} + 1, div), "warm-up span");
      chk_int(tf, -1, "pin moved in warm-up");
    end else begin
      chk_int(tf, exp_span(w + 1, div), "width point");
      chk_int(ti, exp_span(p + 1, div), "period span");
    end
    // stop first, then clear the flip-flop in a later write
    wb(1'b1, `CPW_OFF_UPPER_CTRL, warm ? 8'h05 : 8'h57);
    wb(1'b1, `CPW_OFF_UPPER_CTRL, warm ? 8'h05 : 8'h57);
    ext_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_bit(pin, 1'b1, "pin not high after clear");
    $display("case done: source %0d warm %0d", s, warm);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // pin idles high like a port latch set to one before pulse output
    chk_bit(pin, 1'b1, "pin after reset");
    chk_bit(irq, 1'b0, "interrupt after reset");
    for (int a = 0; a <= 36; a += 4) rd_chk(a[7:0], 32'h0, "reset value");
    for (int a = 8; a <= 20; a += 4) begin
      v = rnd();
      wb(1'b1, a[7:0], v[7:0]);
      rd_chk(a[7:0], {24'h000000, v[7:0]}, "compare readback");
    end
    wb(1'b1, `CPW_OFF_COUNT_LO, 8'hff);
    rd_chk(`CPW_OFF_COUNT_LO, 32'h0, "count written");
    wb(1'b1, 8'h24, 8'hff);
    rd_chk(8'h24, 32'h0, "unmapped read");
    wb(1'b1, `CPW_OFF_UPPER_CTRL, 8'hd7);
    repeat (2) @(posedge ref_clk);
    chk_bit(pin, 1'b0, "preset one");
    rd_chk(`CPW_OFF_STATUS, 32'h1, "status flip-flop");
    wb(1'b1, `CPW_OFF_UPPER_CTRL, 8'h57);
    repeat (2) @(posedge ref_clk);
    chk_bit(pin, 1'b1, "preset zero");
    $display("registers done");
    run_case(3'h6, 1, 16'h0000, 16'h0001, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      run_case(3'h6, 1, {11'h0, v[4:0]}, {11'h0, v[4:0]} + {11'h0, v[12:8]} + 16'h1, 1'b0);
    end
    for (int i = 0; i < 7; i++) run_case(srcs[i], divs[i], 16'h0001, 16'h0002, 1'b0);
    set16(`CPW_OFF_WIDTH_LO, 16'h0002);
    set16(`CPW_OFF_PERIOD_LO, 16'h001e);
    wb(1'b1, `CPW_OFF_LOWER_CTRL, 8'h60);
    wb(1'b1, `CPW_OFF_UPPER_CTRL, 8'h57);
    wb(1'b1, `CPW_OFF_UPPER_CTRL, 8'h5f);
    repeat (10) @(posedge ref_clk);
    wb(1'b1, `CPW_OFF_UPPER_CTRL, 8'h57);
    repeat (20) begin
      @(posedge ref_clk);
      chk_bit(pin, 1'b0, "pin not held at stop");
    end
    wb(1'b1, `CPW_OFF_UPPER_CTRL, 8'h57);
    repeat (2) @(posedge ref_clk);
    chk_bit(pin, 1'b1, "pin not high after clear");
    $display("stop hold done");
    v = rnd();
    run_case(3'h4, 8, 16'h0000, {8'h01, v[7:0]}, 1'b1);
    run_case(3'h6, 1, 16'h0000, {6'h00, v[9:8] | 2'h1, v[7:0]}, 1'b1);
    summarize();
  end

  initial begin
    // all cases together take well under 40000 cycles
    #(60000 * 100);
    fail("watchdog expired");
    summarize();
  end
endmodule
